// file: design/capture_compare_unit.sv
// Capture/compare/PWM unit top: APB register slave, capture value register,
// match/capture flag and PWM duty decode.
// Assumes timers and timer-select bits come from pclk-domain logic outside;
// the pin input comes from the pad and is asynchronous.
//
// Overview of operation
// - Mode 0000 disables unit, resets state.
// - Modes 0100-0111 pick capture edge and ratio.
// - Mode 0010 toggles pin on match, flags.
// - Mode 1000 starts low, match forces high.
// - Mode 1001 starts high, match forces low.
// - Mode 1010 flags only, pin untouched.
// - Modes 11xx PWM with 10-bit duty value.
// - Control bits 7 and 6 read zero.
// - Value bytes and control are read/write.
// - Capture copies selected 16-bit timer count.
// - Capture sets flag; only software clears.
// - New capture overwrites unread old value.
// - Capture/compare use timer 1/3, PWM 2/4.
// - Prescaler cleared when off, leaving capture.
// - Prescale change keeps count; early capture possible.
// - Edge detector sees pin even as output.
// - Compare checks value against selected timer.
// - Writing control zero forces output low.
`include "ccu_defines.svh"

module capture_compare_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  input  wire logic [15:0] first_timer_count,
  input  wire logic [15:0] third_timer_count,
  input  wire logic [7:0]  second_timer_count,
  input  wire logic [7:0]  fourth_timer_count,
  input  wire logic        cc_timer_sel,
  input  wire logic        pwm_timer_sel,
  output logic             match_capture_flag,
  output logic             capture_irq_enable,
  output logic             pwm_active,
  output logic      [9:0]  pwm_duty,
  output logic      [7:0]  pwm_time_base
);

  // Register state.
  logic [7:0]  unit_control_q;
  logic [7:0]  value_low_byte_q;
  logic [7:0]  value_high_byte_q;
  logic        flag_q;
  logic        irq_en_q;

  // Bus handshake state.
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Decoded bus strobes and internal wires.
  logic        setup;
  logic        access_done;
  logic        wr_en;
  logic        mapped;
  logic [31:0] read_word;
  logic [15:0] cc_timer;
  logic [15:0] value;
  logic        capture_fire;
  logic        compare_match;
  logic        wr_ctrl;
  logic        wr_low;
  logic        wr_high;
  logic        wr_status;

  ccu_pkg::mode_t mode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign mode  = unit_control_q[`CCU_MODE_MSB:0];
  assign value = {value_high_byte_q, value_low_byte_q};

  // Capture and compare share one timer pair, picked by the outside select.
  assign cc_timer = cc_timer_sel ? third_timer_count : first_timer_count;

  // APB decode.

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == `CCU_OFS_CONTROL) || (a == `CCU_OFS_VALUE_LOW) ||
           (a == `CCU_OFS_VALUE_HIGH) || (a == `CCU_OFS_STATUS);
  endfunction

  assign setup       = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign mapped      = addr_mapped(paddr);
  assign wr_en       = access_done && pwrite && mapped;
  assign wr_ctrl     = wr_en && (paddr == `CCU_OFS_CONTROL);
  assign wr_low      = wr_en && (paddr == `CCU_OFS_VALUE_LOW);
  assign wr_high     = wr_en && (paddr == `CCU_OFS_VALUE_HIGH);
  assign wr_status   = wr_en && (paddr == `CCU_OFS_STATUS);

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      `CCU_OFS_CONTROL:    read_word[7:0] = unit_control_q & `CCU_CTRL_WR_MASK;
      `CCU_OFS_VALUE_LOW:  read_word[7:0] = value_low_byte_q;
      `CCU_OFS_VALUE_HIGH: read_word[7:0] = value_high_byte_q;
      `CCU_OFS_STATUS: begin
        read_word[`CCU_STAT_FLAG]   = flag_q;
        read_word[`CCU_STAT_IRQ_EN] = irq_en_q;
      end
      default:             read_word = 32'h0000_0000;
    endcase
  end

  // Every transfer takes exactly one wait-free access cycle: the answer is
  // prepared in the setup cycle so that prdata leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (setup) begin
      pready_q  <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q  <= pwrite ? 32'h0000_0000 : read_word;
    end else if (access_done) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
  end

  // Control register.

  // Writing zero drops the mode to off, which clears the prescaler and the
  // compare output latch inside the submodules.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_control_q <= `CCU_CTRL_RESET;
    end else if (wr_ctrl) begin
      unit_control_q <= pwdata[7:0] & `CCU_CTRL_WR_MASK;
    end
  end

  // Capture value register.

  // A capture in the same cycle as a software write wins: the timestamp of a
  // real event is worth more than a value software could write again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_low_byte_q  <= `CCU_VALUE_RESET;
      value_high_byte_q <= `CCU_VALUE_RESET;
    end else if (capture_fire) begin
      value_low_byte_q  <= cc_timer[7:0];
      value_high_byte_q <= cc_timer[15:8];
    end else begin
      if (wr_low) begin
        value_low_byte_q <= pwdata[7:0];
      end
      if (wr_high) begin
        value_high_byte_q <= pwdata[7:0];
      end
    end
  end

  // Status register: flag and interrupt enable.

  // Writing zero to the flag bit clears it; a capture or match in the same
  // cycle keeps it set so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (capture_fire || compare_match) begin
      flag_q <= 1'b1;
    end else if (wr_status && !pwdata[`CCU_STAT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // The enable only travels to the interrupt controller outside.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= 1'b0;
    end else if (wr_status) begin
      irq_en_q <= pwdata[`CCU_STAT_IRQ_EN];
    end
  end

  // PWM decode; period and duty comparison live outside this unit.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_active    <= 1'b0;
      pwm_duty      <= 10'h000;
      pwm_time_base <= 8'h00;
    end else begin
      pwm_active    <= ccu_pkg::is_pwm(mode);
      pwm_duty      <= {value_low_byte_q,
                        unit_control_q[`CCU_DUTY_MSB:`CCU_DUTY_LSB]};
      pwm_time_base <= pwm_timer_sel ? fourth_timer_count
                                     : second_timer_count;
    end
  end

  // Submodules.

  edge_prescaler u_edge_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_raw (pin_in),
    .mode    (mode),
    .fire_q  (capture_fire)
  );

  compare_output u_compare_output (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (mode),
    .value     (value),
    .timer     (cc_timer),
    .match_q   (compare_match),
    .pin_out_q (pin_out),
    .pin_oe_q  (pin_oe)
  );

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign match_capture_flag = flag_q;
  assign capture_irq_enable = irq_en_q;

  // Checks.

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_access_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (apb_setup_s |=> pready)
    else $error("slave did not answer one cycle after setup");

  unmapped_err_a: assert property (apb_setup_s ##0 !addr_mapped(paddr) |=> pslverr)
    else $error("unmapped address not refused");

  ctrl_upper_a: assert property (apb_setup_s ##0 (paddr == `CCU_OFS_CONTROL) && !pwrite
                                 |=> prdata[7:6] == 2'h0)
    else $error("control bits 7 and 6 read non-zero");

  capture_load_a: assert property (capture_fire
                                   |=> value == $past(cc_timer))
    else $error("capture did not load the selected timer");

  flag_set_a: assert property (capture_fire || compare_match |=> flag_q)
    else $error("event did not set the flag");

  flag_hold_a: assert property ($fell(flag_q)
                                |-> $past(wr_status && !pwdata[`CCU_STAT_FLAG]))
    else $error("flag cleared without a software write");

  value_write_a: assert property (apb_access_s ##0 pwrite && (paddr == `CCU_OFS_VALUE_HIGH)
                                  && !capture_fire
                                  |=> value_high_byte_q == $past(pwdata[7:0]))
    else $error("high byte write lost");

  pwm_duty_a: assert property (ccu_pkg::is_pwm(mode) && $stable(unit_control_q)
                               && $stable(value_low_byte_q)
                               |=> pwm_active && pwm_duty == {$past(value_low_byte_q),
                               $past(unit_control_q[5:4])})
    else $error("PWM duty value mismatch");

  off_quiet_a: assert property (mode == `CCU_MODE_OFF |=> !capture_fire && !pin_out
                                && !pin_oe)
    else $error("unit active while disabled");

  compare_pin_a: assert property (compare_match && mode == `CCU_MODE_CMP_LOW
                                  && $stable(mode) && $past(mode, 2) == `CCU_MODE_CMP_LOW
                                  |-> !pin_out)
    else $error("low-on-match mode did not drive low");

  // A write is an access that completes with pwrite high.
  sequence apb_write_s;
    apb_access_s ##0 pwrite;
  endsequence

  // Only the first cycle of equality in a compare mode counts as a match.
  sequence match_start_s;
    ccu_pkg::is_compare(mode) && (value == cc_timer) && !$past(value == cc_timer);
  endsequence

  sequence match_answer_s;
    compare_match ##1 flag_q;
  endsequence

  ready_pulse_a: assert property (apb_access_s |=> !pready)
    else $error("pready stood past one cycle");

  idle_bus_a: assert property (!pready |-> (prdata == 32'h0000_0000) && !pslverr)
    else $error("answer shown outside the access cycle");

  ctrl_write_a: assert property (apb_write_s ##0 (paddr == `CCU_OFS_CONTROL)
    |=> unit_control_q == ($past(pwdata[7:0]) & `CCU_CTRL_WR_MASK))
    else $error("control write lost");

  low_write_a: assert property (apb_write_s ##0 (paddr == `CCU_OFS_VALUE_LOW)
    && !capture_fire |=> value_low_byte_q == $past(pwdata[7:0]))
    else $error("low byte write lost");

  flag_keep_a: assert property (apb_write_s ##0 (paddr == `CCU_OFS_STATUS)
    && pwdata[`CCU_STAT_FLAG] && flag_q |=> flag_q)
    else $error("writing one cleared the flag");

  flag_clear_a: assert property (apb_write_s ##0 (paddr == `CCU_OFS_STATUS)
    && !pwdata[`CCU_STAT_FLAG] && !capture_fire && !compare_match |=> !flag_q)
    else $error("writing zero did not clear the flag");

  irq_write_a: assert property (apb_write_s ##0 (paddr == `CCU_OFS_STATUS)
    |=> irq_en_q == $past(pwdata[`CCU_STAT_IRQ_EN]))
    else $error("interrupt enable write lost");

  unmapped_write_a: assert property (apb_write_s ##0 !addr_mapped(paddr)
    && !capture_fire |=> $stable(unit_control_q) && $stable(value) && $stable(irq_en_q))
    else $error("unmapped write changed a register");

  overwrite_a: assert property (capture_fire && flag_q
    |=> value == $past(cc_timer) && flag_q)
    else $error("capture did not overwrite the unread value");

  capture_third_a: assert property (capture_fire && cc_timer_sel
    |=> value == $past(third_timer_count))
    else $error("capture did not take the third timer");

  match_flag_a: assert property (match_start_s |=> match_answer_s)
    else $error("compare match did not raise match and flag");

  pwm_idle_a: assert property (!ccu_pkg::is_pwm(mode) |=> !pwm_active)
    else $error("PWM flagged outside PWM mode");

  base_fourth_a: assert property (pwm_timer_sel
    |=> pwm_time_base == $past(fourth_timer_count))
    else $error("PWM time base not from the fourth timer");

  base_second_a: assert property (!pwm_timer_sel
    |=> pwm_time_base == $past(second_timer_count))
    else $error("PWM time base not from the second timer");

endmodule // capture_compare_unit

// file: design/ccu_defines.svh
// Constants for the capture/compare unit: register offsets, field layout,
// reset values, mode codes and prescale limits.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

`define CCU_OFS_CONTROL    12'h000
`define CCU_OFS_VALUE_LOW  12'h004
`define CCU_OFS_VALUE_HIGH 12'h008
`define CCU_OFS_STATUS     12'h00C

`define CCU_CTRL_WR_MASK   8'h3F
`define CCU_CTRL_RESET     8'h00
`define CCU_VALUE_RESET    8'h00
`define CCU_MODE_MSB       3
`define CCU_DUTY_MSB       5
`define CCU_DUTY_LSB       4
`define CCU_STAT_FLAG      0
`define CCU_STAT_IRQ_EN    1

`define CCU_MODE_OFF       4'h0
`define CCU_MODE_CMP_TGL   4'h2
`define CCU_MODE_CAP_FALL  4'h4
`define CCU_MODE_CAP_RISE  4'h5
`define CCU_MODE_CAP_4TH   4'h6
`define CCU_MODE_CAP_16TH  4'h7
`define CCU_MODE_CMP_HIGH  4'h8
`define CCU_MODE_CMP_LOW   4'h9
`define CCU_MODE_CMP_SOFT  4'hA

`define CCU_PS_LAST_1      4'h0
`define CCU_PS_LAST_4      4'h3
`define CCU_PS_LAST_16     4'hF

`endif

// file: design/ccu_pkg.sv
// Types and mode decoding shared by the capture/compare unit modules.
// Assumes the defines header is on the include path.
`include "ccu_defines.svh"

package ccu_pkg;

  typedef logic [3:0] mode_t;

  function automatic logic is_capture(input mode_t m);
    return m[3:2] == 2'h1;
  endfunction

  function automatic logic is_pwm(input mode_t m);
    return m[3:2] == 2'h3;
  endfunction

  function automatic logic is_compare(input mode_t m);
    return (m == `CCU_MODE_CMP_TGL) || (m == `CCU_MODE_CMP_HIGH) ||
           (m == `CCU_MODE_CMP_LOW) || (m == `CCU_MODE_CMP_SOFT);
  endfunction

endpackage

// file: design/edge_prescaler.sv
// Pin synchroniser, edge detector and capture prescaler.
// Assumes pin_raw is asynchronous to pclk and mode comes from the pclk domain.
`include "ccu_defines.svh"

module edge_prescaler (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          pin_raw,
  input  wire ccu_pkg::mode_t mode,
  output logic               fire_q
);

  logic       sync1_q;
  logic       sync2_q;
  logic       level_q;
  logic [3:0] count_q;
  logic [3:0] last;
  logic       edge_ok;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The pin is sampled from the pad, so a port write on a driven pin counts too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      level_q <= sync2_q;
    end
  end

  always_comb begin
    unique case (mode)
      `CCU_MODE_CAP_FALL: edge_ok = !sync2_q && level_q;
      `CCU_MODE_CAP_RISE,
      `CCU_MODE_CAP_4TH,
      `CCU_MODE_CAP_16TH: edge_ok = sync2_q && !level_q;
      default:            edge_ok = 1'b0;
    endcase
    unique case (mode)
      `CCU_MODE_CAP_4TH:  last = `CCU_PS_LAST_4;
      `CCU_MODE_CAP_16TH: last = `CCU_PS_LAST_16;
      default:            last = `CCU_PS_LAST_1;
    endcase
  end

  // The counter survives a switch between prescale settings, so a count left
  // above the new limit fires on the very next edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 4'h0;
      fire_q  <= 1'b0;
    end else if (!ccu_pkg::is_capture(mode)) begin
      count_q <= 4'h0;
      fire_q  <= 1'b0;
    end else if (edge_ok) begin
      fire_q  <= count_q >= last;
      count_q <= (count_q >= last) ? 4'h0 : count_q + 4'h1;
    end else begin
      fire_q  <= 1'b0;
    end
  end

  prescale_clear_a: assert property (!ccu_pkg::is_capture(mode) |=> count_q == 4'h0)
    else $error("prescaler counter kept outside capture mode");
  fire_mode_a: assert property (fire_q |-> ccu_pkg::is_capture($past(mode)))
    else $error("capture fired outside capture mode");
  rise_fire_a: assert property ((mode == `CCU_MODE_CAP_RISE) && $stable(mode) && sync2_q
                                && !level_q |=> fire_q)
    else $error("rising edge did not capture");

endmodule // edge_prescaler

// file: design/compare_output.sv
// Compare match detector and compare output latch.
// Assumes value and timer are pclk-domain words.
`include "ccu_defines.svh"

module compare_output (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire ccu_pkg::mode_t mode,
  input  wire logic [15:0]    value,
  input  wire logic [15:0]    timer,
  output logic                match_q,
  output logic                pin_out_q,
  output logic                pin_oe_q
);

  logic           equal_q;
  ccu_pkg::mode_t prev_mode_q;
  logic           entered;
  logic           match;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign entered = mode != prev_mode_q;
  // Only the first cycle of equality matches, so a stopped timer flags once.
  assign match = (value == timer) && !equal_q && ccu_pkg::is_compare(mode);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      equal_q     <= 1'b0;
      prev_mode_q <= `CCU_MODE_OFF;
      match_q     <= 1'b0;
      pin_oe_q    <= 1'b0;
    end else begin
      equal_q     <= value == timer;
      prev_mode_q <= mode;
      match_q     <= match;
      pin_oe_q    <= (mode == `CCU_MODE_CMP_TGL) || (mode == `CCU_MODE_CMP_HIGH) ||
                     (mode == `CCU_MODE_CMP_LOW);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
    end else if (mode == `CCU_MODE_OFF) begin
      pin_out_q <= 1'b0;
    end else if (entered && mode == `CCU_MODE_CMP_HIGH) begin
      pin_out_q <= 1'b0;
    end else if (entered && mode == `CCU_MODE_CMP_LOW) begin
      pin_out_q <= 1'b1;
    end else if (match) begin
      unique case (mode)
        `CCU_MODE_CMP_TGL:  pin_out_q <= !pin_out_q;
        `CCU_MODE_CMP_HIGH: pin_out_q <= 1'b1;
        `CCU_MODE_CMP_LOW:  pin_out_q <= 1'b0;
        default:            pin_out_q <= pin_out_q;
      endcase
    end
  end

  toggle_match_a: assert property (match && mode == `CCU_MODE_CMP_TGL && !entered
                                   |=> pin_out_q != $past(pin_out_q))
    else $error("toggle mode did not toggle on match");
  off_low_a: assert property (mode == `CCU_MODE_OFF |=> !pin_out_q)
    else $error("output latch not low with unit off");
  soft_pin_a: assert property (mode == `CCU_MODE_CMP_SOFT |=> !pin_oe_q)
    else $error("software compare mode drove the pin");

endmodule // compare_output

// file: sim/pin_driver.sv
// Model of the external event source at the capture/compare pin.
// Assumes the bench sets the wanted level just after a rising edge of pclk.
module pin_driver (
  input  wire logic pclk,
  input  wire logic level,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic level_q = 1'b0;

  // The source moves only on whole cycles, so each level stands long enough to be seen.
  always_ff @(posedge pclk) begin
    level_q <= level;
  end

  // The pad shows the unit's own drive while enabled, so the edge detector still sees it.
  assign pin_in = pin_oe ? pin_out : level_q;
endmodule // pin_driver

// file: sim/tb_top.sv
// Self-checking bench for the capture/compare unit: registers, capture, compare, PWM.
// Assumes the design files and the pin model are compiled before it.
`include "ccu_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} reg_row_t;
  typedef struct {logic [3:0] mode; logic oe; logic out0; logic out1;} cmp_row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe;
  logic        level = 1'b0;
  // Timers come from pclk logic, as a synchronous time base must.
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic [7:0]  t2 = 8'h00;
  logic [7:0]  t4 = 8'h00;
  logic        cc_sel = 1'b0;
  logic        pwm_sel = 1'b0;
  logic        flag;
  logic        irq_en;
  logic        pwm_active;
  logic [9:0]  pwm_duty;
  logic [7:0]  pwm_tb;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] e;
  int          n;
  int          mismatches = 0;
  int          n_tests = 0;

  reg_row_t regs [6] = '{
    '{`CCU_OFS_CONTROL,    32'hFFFF_FFFF, 32'h0000_003F, 1'b0},
    '{`CCU_OFS_VALUE_LOW,  32'h1234_56A5, 32'h0000_00A5, 1'b0},
    '{`CCU_OFS_VALUE_HIGH, 32'h0000_005A, 32'h0000_005A, 1'b0},
    '{`CCU_OFS_STATUS,     32'h0000_0002, 32'h0000_0002, 1'b0},
    '{12'h010,             32'h0000_0077, 32'h0000_0000, 1'b1},
    '{`CCU_OFS_CONTROL,    32'h0000_0000, 32'h0000_0000, 1'b0}};
  cmp_row_t cmps [4] = '{'{4'h8, 1'b1, 1'b0, 1'b1}, '{4'h9, 1'b1, 1'b1, 1'b0},
                         '{4'h2, 1'b1, 1'b0, 1'b1}, '{4'hA, 1'b0, 1'b0, 1'b0}};

  capture_compare_unit i_capture_compare_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .first_timer_count(t1), .third_timer_count(t3), .second_timer_count(t2),
    .fourth_timer_count(t4), .cc_timer_sel(cc_sel), .pwm_timer_sel(pwm_sel),
    .match_capture_flag(flag), .capture_irq_enable(irq_en), .pwm_active(pwm_active),
    .pwm_duty(pwm_duty), .pwm_time_base(pwm_tb));

  pin_driver i_pin_driver (
    .pclk(pclk), .level(level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic wrap_up();
    $display("Checks: %0d, mismatches: %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_bit(input logic exp, input logic got);
    chk_word({31'h0, exp}, {31'h0, got});
  endtask

  // Called just after a rising edge. Holds the request until pready is seen high at a
  // rising edge, takes the answer at that edge, releases it and lets one more edge
  // pass, so that whatever the write changed is visible when the task returns.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic ok;
    int   i;
    ok = 1'b0;
    i = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (!ok && i < 16) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
      i++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!ok) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task automatic pulses(input int cnt);
    repeat (cnt) begin
      level <= 1'b1;
      repeat (6) @(posedge pclk);
      level <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  task automatic chk_value(input logic [15:0] v);
    apb(1'b0, `CCU_OFS_VALUE_LOW, 32'h0);
    chk_word({24'h0, v[7:0]}, rdat);
    apb(1'b0, `CCU_OFS_VALUE_HIGH, 32'h0);
    chk_word({24'h0, v[15:8]}, rdat);
  endtask

  task automatic set_mode(input logic [31:0] c);
    apb(1'b1, `CCU_OFS_CONTROL, c);
    apb(1'b1, `CCU_OFS_STATUS, 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk_word(32'h0, rdat);
    end
    foreach (regs[k]) begin
      apb(1'b1, regs[k].a, regs[k].w);
      apb(1'b0, regs[k].a, 32'h0);
      chk_word(regs[k].r, rdat);
      chk_bit(regs[k].e, rerr);
    end
    chk_bit(1'b1, irq_en);
    t2 <= 8'h11;
    t4 <= 8'h22;
    pwm_sel <= 1'b1;
    apb(1'b1, `CCU_OFS_VALUE_LOW, 32'h0000_00B4);
    for (int m = 12; m < 16; m++) begin
      apb(1'b1, `CCU_OFS_CONTROL, 32'(m) | 32'h20);
      repeat (2) @(posedge pclk);
      chk_bit(1'b1, pwm_active);
      chk_word(32'h2D2, {22'h0, pwm_duty});
    end
    chk_word(32'h22, {24'h0, pwm_tb});
    // Each capture mode: no capture before the last qualifying edge, then a capture that loads the selected timer.
    for (int m = 4; m < 8; m++) begin
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      e = m[0] ? 16'hC000 + 16'(m) : 16'h1000 + 16'(m);
      apb(1'b1, `CCU_OFS_CONTROL, 32'h0);
      cc_sel <= m[0];
      t1 <= 16'h1000 + 16'(m);
      t3 <= 16'hC000 + 16'(m);
      set_mode(32'(m));
      chk_bit(1'b0, pwm_active);
      pulses(n - 1);
      chk_bit(1'b0, flag);
      level <= 1'b1;
      repeat (8) @(posedge pclk);
      chk_bit(m != 4, flag);
      level <= 1'b0;
      repeat (8) @(posedge pclk);
      chk_bit(1'b1, flag);
      chk_value(e);
    end
    set_mode(32'h0);
    set_mode(32'h5);
    cc_sel <= 1'b0;
    t1 <= 16'h2222;
    pulses(1);
    chk_value(16'h2222);
    t1 <= 16'h3333;
    pulses(1);
    chk_value(16'h3333);
    apb(1'b1, `CCU_OFS_STATUS, 32'h1);
    chk_bit(1'b1, flag);
    // A direct prescale change keeps the count: 3 edges at 1:4 leave 13 to go at 1:16.
    set_mode(32'h0);
    set_mode(32'h6);
    pulses(3);
    set_mode(32'h7);
    pulses(12);
    chk_bit(1'b0, flag);
    pulses(1);
    chk_bit(1'b1, flag);
    // Turning the unit off drops a partial count, so all 16 edges are needed again.
    set_mode(32'h6);
    pulses(3);
    set_mode(32'h0);
    set_mode(32'h7);
    pulses(15);
    chk_bit(1'b0, flag);
    pulses(1);
    chk_bit(1'b1, flag);
    apb(1'b1, `CCU_OFS_VALUE_LOW, 32'h0);
    apb(1'b1, `CCU_OFS_VALUE_HIGH, 32'h1);
    cc_sel <= 1'b1;
    t1 <= 16'h0100;
    t3 <= 16'h0000;
    foreach (cmps[k]) begin
      set_mode(32'h0);
      chk_bit(1'b0, pin_out);
      set_mode({28'h0, cmps[k].mode});
      chk_bit(cmps[k].oe, pin_oe);
      chk_bit(cmps[k].out0, pin_out);
      chk_bit(1'b0, flag);
      t3 <= 16'h0100;
      repeat (4) @(posedge pclk);
      chk_bit(cmps[k].out1, pin_out);
      chk_bit(1'b1, flag);
      t3 <= 16'h0000;
    end
    wrap_up();
  end
endmodule // tb_top
